/* core/bit_exec.v */
// bit_exec.v: decode and execute of bit test-skip and bit set instructions
// assumes the fetch stage presents one instruction per cycle with a valid
// strobe, and the register file answers reads combinationally
//
// Function
// - opcode 0110 is test-skip-if-clear, fields b,f
// - skip next when tested bit reads 0
// - skip discards prefetched word, runs no-op instead
// - one cycle, two when skip taken
// - opcode 0111 skips next when bit is 1
// - address 0..127, bit 0..7, status untouched
`timescale 1ns/100ps
`include "bit_exec_regs.vh"

module bit_exec #(
   parameter IW = 14,
   parameter DW = 8,
   parameter AW = 7
) (
   input wire clk_in,
   input wire rst_b_in,
   input wire ce_in,
   input wire instr_valid_in,
   input wire [IW-1:0] instr_in,
   input wire [DW-1:0] rf_rdata_in,
   output reg [AW-1:0] rf_addr_out,
   output reg rf_we_out,
   output reg [DW-1:0] rf_wdata_out,
   output reg squash_out,
   output reg skip_taken_out,
   output reg status_we_out
);

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire [3:0] opc = instr_in[`OPC_MSB:`OPC_LSB];
   wire [2:0] bidx = instr_in[`BIDX_MSB:`BIDX_LSB];
   wire [AW-1:0] faddr = instr_in[`ADDR_MSB:`ADDR_LSB];

   // one-hot mask for the selected bit
   function [DW-1:0] bit_mask;
      input [2:0] idx;
      begin
         bit_mask = {{(DW-1){1'b0}}, 1'b1} << idx;
      end
   endfunction

   // ----------------------------------------
   // state and decode results
   // ----------------------------------------
   reg skip_q;
   reg skip_d;
   reg sel_bit;
   reg is_bit_op;
   reg is_clr_op;
   reg is_set_op;
   reg is_bset_op;
   wire do_set;
   wire [DW-1:0] sel_mask;
   wire [DW-1:0] set_data;
   wire slot_consumed;

   // one mask serves both the bit test and the write data
   assign sel_mask = bit_mask(bidx);
   assign set_data = rf_rdata_in | sel_mask;

   // a skip slot is used up by a real word; an idle slot also clears it,
   // because skip_d is forced low while the slot is squashed
   assign slot_consumed = skip_q && instr_valid_in;

   // ----------------------------------------
   // opcode classification
   // ----------------------------------------
   // field decode
   always @* begin
      sel_bit = |(rf_rdata_in & sel_mask);
      is_bit_op = instr_valid_in && !skip_q;
      is_clr_op = 1'h0;
      is_set_op = 1'h0;
      is_bset_op = 1'h0;
      if (is_bit_op) begin
         case (opc)
            `OPC_SKIP_CLEAR: begin
               is_clr_op = 1'h1;
            end
            `OPC_SKIP_SET: begin
               is_set_op = 1'h1;
            end
            `OPC_SET_BIT: begin
               is_bset_op = 1'h1;
            end
            default: begin
               // other opcodes belong to other units: no strobe here
               is_clr_op = 1'h0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // skip decision
   // ----------------------------------------
   always @* begin
      skip_d = `SKIP_RESET;
      if (is_clr_op) begin
         skip_d = !sel_bit;
      end else if (is_set_op) begin
         skip_d = sel_bit;
      end
   end

   assign do_set = is_bset_op;

   // ----------------------------------------
   // execute
   // ----------------------------------------
   // skip adds exactly one cycle
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         skip_q <= `SKIP_RESET;
      end else if (ce_in) begin
         if (slot_consumed) begin
            skip_q <= `SKIP_RESET;
         end else begin
            skip_q <= skip_d;
         end
      end
   end

   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         squash_out <= 1'h0;
      end else if (ce_in) begin
         squash_out <= skip_d;
      end
   end

   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         skip_taken_out <= 1'h0;
      end else if (ce_in) begin
         skip_taken_out <= skip_d;
      end
   end

   // the register file sees the address combinationally through instr_in;
   // rf_addr_out is the registered copy that pairs with the write strobe
   // seven-bit address
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rf_addr_out <= {AW{1'h0}};
      end else if (ce_in) begin
         rf_addr_out <= faddr;
      end
   end

   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         status_we_out <= 1'h0;
      end else if (ce_in) begin
         status_we_out <= 1'h0;
      end
   end

   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rf_we_out <= 1'h0;
      end else if (ce_in) begin
         rf_we_out <= do_set;
      end
   end

   // read-modify-write sets one bit
   // data is loaded every cycle to save a mux; it only matters with the strobe
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rf_wdata_out <= {DW{1'h0}};
      end else if (ce_in) begin
         rf_wdata_out <= set_data;
      end
   end

endmodule // bit_exec

/* core/bit_exec_regs.vh */
// bit_exec_regs.vh: opcode fields and encodings for the bit test/set executor
// assumes 14-bit instruction words, 7-bit register addresses, 8-bit data
`ifndef BIT_EXEC_REGS_VH
`define BIT_EXEC_REGS_VH

// ----------------------------------------
// instruction fields
// ----------------------------------------
`define OPC_MSB 13
`define OPC_LSB 10
`define BIDX_MSB 9
`define BIDX_LSB 7
`define ADDR_MSB 6
`define ADDR_LSB 0

// ----------------------------------------
// opcode encodings (upper four bits)
// ----------------------------------------
`define OPC_SET_BIT 4'h5
`define OPC_SKIP_CLEAR 4'h6
`define OPC_SKIP_SET 4'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define SKIP_RESET 1'h0

`endif

/* verification/bit_exec_sva.sv */
// bit_exec_sva.sv: port assertions for bit_exec
// assumes one instruction clock and an async active-low reset
`timescale 1ns/100ps
module bit_exec_sva (input wire clk_in, rst_b_in, ce_in, instr_valid_in, rf_we_out, squash_out,
   skip_taken_out, status_we_out, input wire [13:0] instr_in, input wire [7:0] rf_rdata_in,
   rf_wdata_out, input wire [6:0] rf_addr_out);
   // a squashed slot is never a taken instruction
   wire t = ce_in & instr_valid_in & !squash_out;
   wire h = rf_rdata_in[instr_in[9:7]];
   wire c = t & (instr_in[13:10] == 4'h6);
   wire s = t & (instr_in[13:10] == 4'h7);
   wire w = t & (instr_in[13:10] == 4'h5);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   a_addr_ok: assert property (c |=> rf_addr_out == $past(instr_in[6:0])) else $error("addr");
   a_clr_skip: assert property (c & !h |=> squash_out & skip_taken_out) else $error("clr");
   a_slot_drop: assert property (squash_out & ce_in & instr_valid_in |=> !squash_out & !rf_we_out)
      else $error("drop");
   a_no_skip: assert property ((c & h) | (s & !h) |=> !squash_out) else $error("noskip");
   a_set_skip: assert property (s & h |=> squash_out) else $error("set");
   a_status_kept: assert property (t |=> !status_we_out) else $error("status");
   a_bit_write: assert property (w |=> rf_we_out &
      rf_wdata_out == ($past(rf_rdata_in) | 8'h01 << $past(instr_in[9:7]))) else $error("bitset");
endmodule // bit_exec_sva
bind bit_exec bit_exec_sva chk_u (.*);

/* verification/testbench.sv */
// testbench.sv: directed scenarios for bit_exec
// assumes the checker is bound from its own file
`timescale 1ns/100ps
module testbench;
   reg clk_in = 0, rst_b_in = 0, ce_in = 1, instr_valid_in = 0;
   reg [13:0] instr_in = 14'h0;
   reg [7:0] rf_rdata_in = 8'h0;
   wire [6:0] rf_addr_out;
   wire [7:0] rf_wdata_out;
   wire rf_we_out, squash_out, skip_taken_out, status_we_out;
   integer err_total = 0, check_count = 0;
   bit_exec dut_u (.*);
   initial forever #10 clk_in = ~clk_in;
   task chk(input [15:0] n, input [7:0] s, e);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %s exp %h seen %h", n, e, s);
      end
   endtask
   task ex(input [13:0] i, input [7:0] r);
      @(negedge clk_in) {instr_in, rf_rdata_in, instr_valid_in} = {i, r, 1'b1};
      @(posedge clk_in) #1;
   endtask
   task t_clr;
      ex(14'h1883, 8'h00);
      chk("sk", skip_taken_out, 1);
      chk("ad", rf_addr_out, 3);
      ex(14'h1483, 8'h00);
      chk("we", rf_we_out, 0);
   endtask
   task t_edge;
      ex(14'h1bff, 8'h7f);
      chk("ad", rf_addr_out, 8'h7f);
      ex(14'h0, 8'h00);
      ex(14'h1883, 8'h02);
      chk("sq", squash_out, 0);
   endtask
   task t_set;
      ex(14'h1c83, 8'h02);
      chk("sq", squash_out, 1);
      ex(14'h1c83, 8'h02);
      chk("sq", squash_out, 0);
      ex(14'h1785, 8'h0a);
      chk("wd", rf_wdata_out, 8'h8a);
      chk("st", status_we_out, 0);
   endtask
   task t_misc;
      ex(14'h1785, 8'h0a);
      chk("we", rf_we_out, 1);
      @(negedge clk_in) instr_valid_in = 0;
      @(posedge clk_in) #1;
      chk("we", rf_we_out, 0);
      ex(14'h1883, 8'h00);
      @(negedge clk_in) ce_in = 0;
      @(posedge clk_in) #1;
      chk("sq", squash_out, 1);
      @(negedge clk_in) ce_in = 1;
      rst_b_in = 0;
      instr_valid_in = 0;
      #1 chk("sq", squash_out, 0);
      @(negedge clk_in) rst_b_in = 1;
      ex(14'h1483, 8'h00);
      chk("we", rf_we_out, 1);
      chk("wd", rf_wdata_out, 8'h02);
   endtask
   task test_done;
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #60 rst_b_in = 1;
      t_clr;
      t_edge;
      t_set;
      t_misc;
      test_done;
   end
endmodule // testbench
